// ---- rtl/ext_edge_detect.sv ----
// edge detector for the external interrupt pin with selectable polarity
`timescale 1ns/1ps
`default_nettype none
module ext_edge_detect (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // detector side of the event interface
  src_event_if.ext_det src
);
  logic prev_q;
  logic primed_q;

  // ----------------------------------------------------------------
  // pin history
  // ----------------------------------------------------------------
  // primed blocks a false edge from the reset value of the history
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_q <= 1'b0;
      primed_q <= 1'b0;
    end else begin
      prev_q <= src.ext_irq_pin;
      primed_q <= 1'b1;
    end
  end

  // rising edge when select is one, falling edge when zero
  assign src.ext_event = primed_q & (src.ext_edge_select ?
                         (src.ext_irq_pin & ~prev_q) :
                         (~src.ext_irq_pin & prev_q)); // R11
endmodule
`default_nettype wire

// ---- rtl/interrupt_enable_flag_logic.sv ----
// interrupt enable and flag registers with the request gating to the core
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "irq_defines.svh"

// What this block does
// R1 - control bit 7 globally enables core request
// R2 - control bit 6 enables peripheral group
// R3 - control bit 5 enables timer0 overflow
// R4 - control bit 4 enables external pin
// R5 - external flag bit 1, software clears only
// R6 - port change flag bit 0 on mismatch
// R7 - mismatch persists until port read, re-sets flag
// R8 - peripheral needs group, own, global enable
// R9 - eight-bit peripheral enable register, fixed order
// R10 - flags set regardless of any enable
// R11 - external edge polarity from select bit
// R12 - timer0 flag bit 2, change enable bit 3
// R13 - request is global AND of gated sources
module interrupt_enable_flag_logic
  import irq_pkg::*;
#(
  parameter int PORT_W = `PORT_W_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  // interrupt sources
  input wire logic timer0_ovf_pulse,
  input wire logic ext_irq_pin,
  input wire logic [PORT_W-1:0] port_b_upper_pins,
  input wire logic port_b_read,
  input wire logic [7:0] periph_flags,
  // requests
  output logic irq_request,
  output logic event_irq
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  generate
    if (PORT_W < 1 || PORT_W > 8) begin : g_bad_width
      $error("PORT_W must lie between 1 and 8");
    end
  endgenerate

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg8_t ctrl_q;
  reg8_t ctrl_d;
  reg8_t periph_en_q;
  reg8_t config_q;
  evt_t evt_stat_q;
  evt_t evt_stat_d;
  evt_t evt_mask_q;
  evt_t evt_in;
  reg8_t rd_mux;
  reg8_t rd_data_q;
  reg8_t periph_gated;
  logic irq_d;
  logic irq_q;
  logic event_irq_q;
  logic core_any;
  logic periph_any;
  logic hit_ctrl;
  logic hit_pen;
  logic hit_cfg;
  logic hit_stat;
  logic hit_mask;
  logic wr_ctrl;
  logic wr_pen;
  logic wr_cfg;
  logic wr_stat;
  logic wr_mask;

  src_event_if #(.PW(PORT_W)) src ();

  // ----------------------------------------------------------------
  // pin event detectors
  // ----------------------------------------------------------------
  assign src.ext_irq_pin = ext_irq_pin;
  assign src.ext_edge_select = config_q[`EDGE_SEL_BIT];
  assign src.port_b_upper_pins = port_b_upper_pins;
  assign src.port_b_read = port_b_read;

  ext_edge_detect u_ext (
    .clk(clk),
    .reset(reset),
    .src(src)
  );

  port_change_detect #(.PW(PORT_W)) u_pchg (
    .clk(clk),
    .reset(reset),
    .src(src)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign hit_ctrl = (addr == `ADDR_CORE_CTRL);
  assign hit_pen = (addr == `ADDR_PERIPH_EN);
  assign hit_cfg = (addr == `ADDR_CONFIG);
  assign hit_stat = (addr == `ADDR_EVT_STAT);
  assign hit_mask = (addr == `ADDR_EVT_MASK);
  assign wr_ctrl = wr_en & hit_ctrl;
  assign wr_pen = wr_en & hit_pen;
  assign wr_cfg = wr_en & hit_cfg;
  assign wr_stat = wr_en & hit_stat;
  assign wr_mask = wr_en & hit_mask;

  // ----------------------------------------------------------------
  // core control register: enables and flags
  // ----------------------------------------------------------------
  // a hardware set in the same cycle as a software clear wins, so no
  // event is lost; only software can clear a flag
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = wr_data; // R1 R2 R3 R4
    end
    ctrl_d[`T0_FLAG_BIT] = ctrl_d[`T0_FLAG_BIT] | timer0_ovf_pulse; // R12 R10
    ctrl_d[`EXT_FLAG_BIT] = ctrl_d[`EXT_FLAG_BIT] | src.ext_event; // R5 R10
    // a standing mismatch wins over a clear in the same cycle, so the flag stays set
    ctrl_d[`PCHG_FLAG_BIT] = ctrl_d[`PCHG_FLAG_BIT] | src.port_mismatch; // R6 R7
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= `CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // peripheral enable and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      periph_en_q <= `PERIPH_EN_RST;
    end else if (wr_pen) begin
      periph_en_q <= wr_data; // R9
    end
  end

  // only the edge select bit is stored; the rest reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      config_q <= `CONFIG_RST;
    end else if (wr_cfg) begin
      config_q <= {7'h00, wr_data[`EDGE_SEL_BIT]};
    end
  end

  // ----------------------------------------------------------------
  // request gating
  // ----------------------------------------------------------------
  // one gate per peripheral source, bit 7 parallel port down to bit 0
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_periph
      assign periph_gated[i] = periph_flags[i] & periph_en_q[i]; // R9
    end
  endgenerate

  assign periph_any = ctrl_q[`PGROUP_EN_BIT] & (|periph_gated); // R2 R8
  assign core_any = (ctrl_q[`T0_EN_BIT] & ctrl_q[`T0_FLAG_BIT]) | // R3
                    (ctrl_q[`EXT_EN_BIT] & ctrl_q[`EXT_FLAG_BIT]) | // R4
                    (ctrl_q[`PCHG_EN_BIT] & ctrl_q[`PCHG_FLAG_BIT]); // R12
  assign irq_d = ctrl_q[`GLOBAL_EN_BIT] & (core_any | periph_any); // R1 R13

  // registered so the core sees a clean level; costs one cycle of lag
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // event status, mask and event interrupt
  // ----------------------------------------------------------------
  // the mismatch is a level, so its status bit cannot be cleared
  // until the port has been read
  assign evt_in[`EVT_PCHG_BIT] = src.port_mismatch;
  assign evt_in[`EVT_EXT_BIT] = src.ext_event;
  assign evt_in[`EVT_T0_BIT] = timer0_ovf_pulse;
  assign evt_in[`EVT_REQ_BIT] = irq_d & ~irq_q;

  // write one to clear, a new event in the same cycle wins
  always_comb begin
    evt_stat_d = evt_stat_q;
    if (wr_stat) begin
      evt_stat_d = evt_stat_q & ~wr_data[3:0];
    end
    evt_stat_d = evt_stat_d | evt_in;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      evt_stat_q <= `EVT_RST;
    end else begin
      evt_stat_q <= evt_stat_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      evt_mask_q <= `EVT_RST;
    end else if (wr_mask) begin
      evt_mask_q <= wr_data[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      event_irq_q <= 1'b0;
    end else begin
      event_irq_q <= |(evt_stat_q & evt_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // unmapped addresses read zero; data stand for one cycle only
  always_comb begin
    rd_mux = `RD_IDLE;
    if (hit_ctrl) begin
      rd_mux = ctrl_q;
    end else if (hit_pen) begin
      rd_mux = periph_en_q;
    end else if (hit_cfg) begin
      rd_mux = config_q;
    end else if (hit_stat) begin
      rd_mux = {4'h0, evt_stat_q};
    end else if (hit_mask) begin
      rd_mux = {4'h0, evt_mask_q};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_q <= `RD_IDLE;
    end else begin
      rd_data_q <= rd_en ? rd_mux : `RD_IDLE;
    end
  end

  assign rd_data = rd_data_q;
  assign irq_request = irq_q;
  assign event_irq = event_irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_global_block;
    !ctrl_q[`GLOBAL_EN_BIT] |=> !irq_request;
  endproperty
  a_global_block: assert property (p_global_block) // R1
    else $error("request raised with global enable clear");

  property p_group_block;
    (ctrl_q[`GLOBAL_EN_BIT] && !ctrl_q[`PGROUP_EN_BIT] && !core_any) |=> !irq_request;
  endproperty
  a_group_block: assert property (p_group_block) // R2
    else $error("peripheral passed with group enable clear");

  property p_t0_request;
    (ctrl_q[`GLOBAL_EN_BIT] && ctrl_q[`T0_EN_BIT] && ctrl_q[`T0_FLAG_BIT]) |=> irq_request;
  endproperty
  a_t0_request: assert property (p_t0_request) // R3
    else $error("enabled timer0 flag gave no request");

  property p_ext_request;
    (ctrl_q[`GLOBAL_EN_BIT] && ctrl_q[`EXT_EN_BIT] && ctrl_q[`EXT_FLAG_BIT]) |=> irq_request;
  endproperty
  a_ext_request: assert property (p_ext_request) // R4
    else $error("enabled external flag gave no request");

  property p_ext_hold;
    (ctrl_q[`EXT_FLAG_BIT] && !wr_ctrl) |=> ctrl_q[`EXT_FLAG_BIT];
  endproperty
  a_ext_hold: assert property (p_ext_hold) // R5
    else $error("external flag cleared without a write");

  property p_pchg_set;
    src.port_mismatch |=> ctrl_q[`PCHG_FLAG_BIT];
  endproperty
  a_pchg_set: assert property (p_pchg_set) // R6
    else $error("mismatch did not set port change flag");

  property p_pchg_reset_after_clear;
    (wr_ctrl && !wr_data[`PCHG_FLAG_BIT] && src.port_mismatch) |=>
      ctrl_q[`PCHG_FLAG_BIT] ##1 (ctrl_q[`PCHG_FLAG_BIT] || !$past(src.port_mismatch));
  endproperty
  a_pchg_reset_after_clear: assert property (p_pchg_reset_after_clear) // R7
    else $error("clear won over a standing mismatch");

  property p_periph_request;
    (ctrl_q[`GLOBAL_EN_BIT] && ctrl_q[`PGROUP_EN_BIT] && (|periph_gated)) |=> irq_request;
  endproperty
  a_periph_request: assert property (p_periph_request) // R8
    else $error("enabled peripheral gave no request");

  property p_periph_en_write;
    wr_pen |=> (periph_en_q == $past(wr_data));
  endproperty
  a_periph_en_write: assert property (p_periph_en_write) // R9
    else $error("peripheral enable register not written");

  property p_flag_ignores_enable;
    (timer0_ovf_pulse && !ctrl_q[`T0_EN_BIT] && !ctrl_q[`GLOBAL_EN_BIT]) |=>
      ctrl_q[`T0_FLAG_BIT];
  endproperty
  a_flag_ignores_enable: assert property (p_flag_ignores_enable) // R10
    else $error("timer0 flag gated by an enable");

  property p_edge_polarity;
    src.ext_event |-> (config_q[`EDGE_SEL_BIT] ? ext_irq_pin : !ext_irq_pin) &&
      (ext_irq_pin != $past(ext_irq_pin));
  endproperty
  a_edge_polarity: assert property (p_edge_polarity) // R11
    else $error("external event on the wrong edge");

  property p_request_cause;
    irq_request |-> $past(ctrl_q[`GLOBAL_EN_BIT]) && $past(core_any || periph_any);
  endproperty
  a_request_cause: assert property (p_request_cause) // R13
    else $error("request without an enabled cause");

  c_periph_irq: cover property (ctrl_q[`PGROUP_EN_BIT] && (|periph_gated) ##1 irq_request);
  c_ext_event: cover property (src.ext_event ##1 ctrl_q[`EXT_FLAG_BIT]);
  c_pchg_cleared: cover property (port_b_read ##1 !src.port_mismatch ##1 wr_ctrl);
  c_event_irq: cover property (wr_stat ##1 !event_irq ##[1:4] event_irq);
endmodule
`default_nettype wire

// ---- rtl/irq_defines.svh ----
// register map, field positions and reset values of the interrupt enable and flag logic
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_CORE_CTRL 8'h0b
`define ADDR_PERIPH_EN 8'h8c
`define ADDR_CONFIG 8'h90
`define ADDR_EVT_STAT 8'h91
`define ADDR_EVT_MASK 8'h92

// ----------------------------------------------------------------
// core_irq_control fields
// ----------------------------------------------------------------
`define GLOBAL_EN_BIT 7
`define PGROUP_EN_BIT 6
`define T0_EN_BIT 5
`define EXT_EN_BIT 4
`define PCHG_EN_BIT 3
`define T0_FLAG_BIT 2
`define EXT_FLAG_BIT 1
`define PCHG_FLAG_BIT 0

// ----------------------------------------------------------------
// configuration and event status fields
// ----------------------------------------------------------------
`define EDGE_SEL_BIT 0
`define EVT_PCHG_BIT 0
`define EVT_EXT_BIT 1
`define EVT_T0_BIT 2
`define EVT_REQ_BIT 3

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define PORT_W_DEF 4
`define CTRL_RST 8'h00
`define PERIPH_EN_RST 8'h00
`define CONFIG_RST 8'h01
`define EVT_RST 4'h0
`define RD_IDLE 8'h00

`endif

// ---- rtl/irq_pkg.sv ----
// types shared by the interrupt enable and flag logic
package irq_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [7:0] addr_t;
  typedef logic [3:0] evt_t;
endpackage

// ---- rtl/port_change_detect.sv ----
// mismatch detector for the upper port pins against their last latched value
`timescale 1ns/1ps
`default_nettype none
module port_change_detect #(
  parameter int PW = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // detector side of the event interface
  src_event_if.pc_det src
);
  logic [PW-1:0] latched_q;
  logic primed_q;

  // ----------------------------------------------------------------
  // latch of the pin values
  // ----------------------------------------------------------------
  // refreshed only by a software read of the port, so the mismatch
  // stands until that read; the first cycle after reset seeds it
  always_ff @(posedge clk) begin
    if (reset) begin
      latched_q <= '0;
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
      if (src.port_b_read || !primed_q) begin
        latched_q <= src.port_b_upper_pins; // R7
      end
    end
  end

  assign src.port_mismatch = primed_q & (src.port_b_upper_pins != latched_q); // R6
endmodule
`default_nettype wire

// ---- rtl/src_event_if.sv ----
// interface between the interrupt logic and its two pin event detectors
`timescale 1ns/1ps
`default_nettype none
interface src_event_if #(
  parameter int PW = 4
);
  logic ext_irq_pin;
  logic ext_edge_select;
  logic ext_event;
  logic [PW-1:0] port_b_upper_pins;
  logic port_b_read;
  logic port_mismatch;

  modport ext_det (input ext_irq_pin, input ext_edge_select, output ext_event);
  modport pc_det (input port_b_upper_pins, input port_b_read, output port_mismatch);
  modport ctl (
    output ext_irq_pin, output ext_edge_select, output port_b_upper_pins,
    output port_b_read, input ext_event, input port_mismatch
  );
endinterface
`default_nettype wire

// ---- sim/interrupt_enable_flag_logic_test.sv ----
// self-checking testbench of the interrupt enable and flag logic
`timescale 1ns/1ps
`default_nettype none
`include "irq_defines.svh"
module interrupt_enable_flag_logic_test;
  import irq_pkg::*;
  localparam addr_t CTRL = `ADDR_CORE_CTRL;
  localparam addr_t PIE = `ADDR_PERIPH_EN;
  localparam addr_t CFG = `ADDR_CONFIG;
  localparam addr_t STAT = `ADDR_EVT_STAT;
  localparam addr_t MASK = `ADDR_EVT_MASK;
  logic clk, reset, wr_en, rd_en, irq_request, event_irq;
  logic timer0_ovf_pulse, ext_irq_pin, port_b_read;
  logic [3:0] port_b_upper_pins;
  addr_t addr;
  reg8_t wr_data, rd_data, periph_flags;
  int error_cnt = 0;
  int checks_done = 0;

  // ----------------------------------------------------------------
  // design and its sources
  // ----------------------------------------------------------------
  interrupt_enable_flag_logic uut (
    .clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .timer0_ovf_pulse(timer0_ovf_pulse),
    .ext_irq_pin(ext_irq_pin), .port_b_upper_pins(port_b_upper_pins),
    .port_b_read(port_b_read), .periph_flags(periph_flags),
    .irq_request(irq_request), .event_irq(event_irq)
  );
  irq_src_model src (
    .clk(clk), .timer0_ovf_pulse(timer0_ovf_pulse), .ext_irq_pin(ext_irq_pin),
    .port_b_upper_pins(port_b_upper_pins), .port_b_read(port_b_read),
    .periph_flags(periph_flags)
  );

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input addr_t a, input reg8_t d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, so sample just then
  task automatic rd(input addr_t a, input reg8_t exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask

  // both requests are registered one cycle behind their cause
  task automatic irq(input logic req, input logic evt);
    @(posedge clk);
    #1 chk({6'h00, irq_request, event_irq}, {6'h00, req, evt});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // a hang counts as a mismatch and still ends in the closing report
  initial begin
    idle(20000);
    error_cnt++;
    $display("BAD %0t run did not finish", $time);
    close_out();
  end

  initial begin
    reset = 1'b1;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    idle(8);
    reset <= 1'b0;
    // reset values, unmapped place and the enable register
    rd(CTRL, 8'h00);
    rd(PIE, 8'h00);
    rd(CFG, 8'h01);
    rd(STAT, 8'h00);
    rd(MASK, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    wr(PIE, 8'ha5);
    rd(PIE, 8'ha5);
    // read data stand for one cycle only, then fall back to zero
    @(posedge clk);
    #1 chk(rd_data, 8'h00);
    wr(PIE, 8'h5a);
    rd(PIE, 8'h5a);
    wr(PIE, 8'h00);
    // timer overflow with every enable off, then gated on and off
    src.pulse_timer();
    irq(1'b0, 1'b0);
    rd(CTRL, 8'h04);
    wr(CTRL, 8'ha4);
    irq(1'b1, 1'b0);
    wr(CTRL, 8'h24);
    irq(1'b0, 1'b0);
    wr(CTRL, 8'h84);
    irq(1'b0, 1'b0);
    // external pin, both edge selections; only the selected edge counts
    for (int s = 1; s >= 0; s--) begin
      wr(CFG, 8'(s));
      wr(CTRL, 8'h90);
      src.set_pin(1'b1);
      idle(2);
      rd(CTRL, (s == 1) ? 8'h92 : 8'h90);
      wr(CTRL, 8'h90);
      src.set_pin(1'b0);
      idle(2);
      rd(CTRL, (s == 1) ? 8'h90 : 8'h92);
      irq(s == 0, 1'b0);
    end
    idle(20);
    rd(CTRL, 8'h92);
    wr(CTRL, 8'h82);
    irq(1'b0, 1'b0);
    // port change: flag stays set through a clear while the mismatch lasts
    wr(CTRL, 8'h88);
    src.set_port(4'h5);
    idle(2);
    rd(CTRL, 8'h89);
    irq(1'b1, 1'b0);
    wr(CTRL, 8'h88);
    rd(CTRL, 8'h89);
    wr(CTRL, 8'h81);
    irq(1'b0, 1'b0);
    src.read_port();
    wr(CTRL, 8'h88);
    rd(CTRL, 8'h88);
    irq(1'b0, 1'b0);
    // peripheral sources need group, own and global enables
    src.set_flags(8'h01);
    wr(PIE, 8'h01);
    wr(CTRL, 8'h80);
    irq(1'b0, 1'b0);
    wr(CTRL, 8'hc0);
    for (int b = 0; b < 8; b++) begin
      src.set_flags(8'h01 << b);
      wr(PIE, 8'h01 << b);
      irq(1'b1, 1'b0);
      src.set_flags(~(8'h01 << b));
      irq(1'b0, 1'b0);
    end
    wr(PIE, 8'hff);
    irq(1'b1, 1'b0);
    wr(CTRL, 8'h80);
    irq(1'b0, 1'b0);
    wr(CTRL, 8'h40);
    irq(1'b0, 1'b0);
    // event status, mask and its interrupt line
    wr(CTRL, 8'h00);
    src.set_flags(8'h00);
    // every event kind has fired by now and none was cleared yet
    rd(STAT, 8'h0f);
    wr(STAT, 8'h0f);
    rd(STAT, 8'h00);
    src.pulse_timer();
    rd(STAT, 8'h04);
    wr(MASK, 8'h04);
    irq(1'b0, 1'b1);
    wr(STAT, 8'h04);
    irq(1'b0, 1'b0);
    rd(MASK, 8'h04);
    // a reset in mid-run returns registers and request lines to idle
    wr(CTRL, 8'h98);
    @(posedge clk);
    reset <= 1'b1;
    idle(2);
    reset <= 1'b0;
    irq(1'b0, 1'b0);
    rd(CTRL, 8'h00);
    rd(MASK, 8'h00);
    rd(CFG, 8'h01);
    close_out();
  end
endmodule
`default_nettype wire

// ---- sim/irq_src_model.sv ----
// behavioural model of the software hooks and interrupt sources around the block
`timescale 1ns/1ps
`default_nettype none
module irq_src_model #(
  parameter int PW = 4
) (
  // clock
  input wire logic clk,
  // sources towards the interrupt logic
  output logic timer0_ovf_pulse,
  output logic ext_irq_pin,
  output logic [PW-1:0] port_b_upper_pins,
  output logic port_b_read,
  output logic [7:0] periph_flags
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  // quiet sources from time zero so the design never samples an unknown
  initial begin
    timer0_ovf_pulse = 1'b0;
    ext_irq_pin = 1'b0;
    port_b_upper_pins = '0;
    port_b_read = 1'b0;
    periph_flags = 8'h00;
  end

  // ----------------------------------------------------------------
  // source actions, each launched just after a rising edge
  // ----------------------------------------------------------------
  // overflow is a single-cycle pulse; a longer one would look like two events
  task automatic pulse_timer();
    @(posedge clk);
    timer0_ovf_pulse <= 1'b1;
    @(posedge clk);
    timer0_ovf_pulse <= 1'b0;
  endtask

  task automatic set_pin(input logic v);
    @(posedge clk);
    ext_irq_pin <= v;
  endtask

  task automatic set_port(input logic [PW-1:0] v);
    @(posedge clk);
    port_b_upper_pins <= v;
  endtask

  // software reads the port first, so the mismatch is gone before the flag clear
  task automatic read_port();
    @(posedge clk);
    port_b_read <= 1'b1;
    @(posedge clk);
    port_b_read <= 1'b0;
  endtask

  task automatic set_flags(input logic [7:0] v);
    @(posedge clk);
    periph_flags <= v;
  endtask
endmodule
`default_nettype wire
